//--- hw/vcp_capture_port.sv
/*
 * Video capture port path: pin sync, inline colour conversion, 4K-byte
 * buffer, overflow and lockup tracking, frame and descriptor writes.
 * Assumes pixel pins are asynchronous to core_clk and the configuration
 * inputs come from logic on core_clk.
 */
// Behaviour
// - RGB goes to YUV444, then 444-to-422
// - YUV422 upsampled to 444, then to RGB
// - 4K bytes buffering; overflow only beyond it
// - Overflow event raised; lockup follows it only in single-channel conversion
// - Lockup only with inline conversion; overflow locks only single-channel
// - Port control bit 23 holds port reset
// - Tiled frame data means tiled descriptors
// - Descriptors never overwrite frame data
// - No split tiled/non-tiled placement setting
`timescale 1ns/10ps
`default_nettype none
`include "vcp_defines.svh"

module vcp_capture_port (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire vcp_pkg::vcp_pix_t      pix_in,
    input  wire logic [31:0]            port_ctrl,
    input  wire logic                   port_enable,
    input  wire vcp_pkg::vcp_conv_t     conv_mode,
    input  wire logic                   single_channel,
    input  wire logic                   tiled_mode,
    input  wire logic [`VCP_ADDR_W-1:0] frame_base,
    output vcp_pkg::vcp_wr_t            dma_wr,
    output logic                        dma_valid,
    input  wire logic                   dma_ready,
    output logic                        overflow_evt,
    output logic                        locked,
    output logic                        frame_busy
);
    import vcp_pkg::*;

    vcp_pix_t               pin_s1;
    vcp_pix_t               pin_s2;
    vcp_pix_t               st_a;
    vcp_pix_t               st_b;
    logic                   port_rst;
    logic                   conv_active;
    logic                   accept;
    logic                   phase_a;
    logic                   phase_b;
    logic [7:0]             cb_hold;
    logic [7:0]             cr_hold;
    logic [`VCP_CNT_W-1:0]  line_pix;
    logic [`VCP_CNT_W-1:0]  line_cnt;
    logic [`VCP_CNT_W-1:0]  min_pix;
    logic                   short_line;
    logic                   ovf_now;
    logic                   desc_pend;
    logic                   desc_push;
    logic                   data_push;
    logic [`VCP_DATA_W-1:0] desc_data;
    logic [`VCP_ADDR_W-1:0] frame_addr;
    logic                   data_tiled;
    logic                   fifo_in_ready;
    logic                   fifo_out_valid;
    vcp_wr_t                wr_word;
    vcp_wr_t                fifo_out;

    ////////////////////////////////////////////////////////////////////////
    // Clamp a signed result to 8 bits
    function automatic logic [7:0] vcp_clamp(input int x);
        return (x < 0) ? 8'h00 : (x > 255) ? 8'hFF : x[7:0];
    endfunction : vcp_clamp

    // RGB to YUV444, fixed-point BT.601 studio range
    function automatic logic [23:0] vcp_rgb_to_yuv(input logic [23:0] p);
        int r = int'(p[23:16]);
        int g = int'(p[15:8]);
        int b = int'(p[7:0]);
        return {vcp_clamp(((66 * r + 129 * g + 25 * b + 128) >>> 8) + 16),
                vcp_clamp(((-38 * r - 74 * g + 112 * b + 128) >>> 8) + 128),
                vcp_clamp(((112 * r - 94 * g - 18 * b + 128) >>> 8) + 128)};
    endfunction : vcp_rgb_to_yuv

    // YUV444 to RGB, fixed-point
    function automatic logic [23:0] vcp_yuv_to_rgb(input logic [23:0] p);
        int y = int'(p[23:16]);
        int u = int'(p[15:8]) - 128;
        int v = int'(p[7:0]) - 128;
        return {vcp_clamp(y + ((359 * v) >>> 8)),
                vcp_clamp(y - ((88 * u + 183 * v) >>> 8)),
                vcp_clamp(y + ((454 * u) >>> 8))};
    endfunction : vcp_yuv_to_rgb

    ////////////////////////////////////////////////////////////////////////
    // port reset bit
    assign port_rst    = reset || port_ctrl[`VCP_PORT_RST_BIT];
    assign conv_active = (conv_mode != VCP_CONV_NONE);
    // Finish a started frame even after the port is disabled
    assign accept      = pin_s2.valid && (port_enable || frame_busy) && !locked;
    assign min_pix     = (conv_mode == VCP_CONV_RGB2YUV) ? `VCP_MIN_DOWN_PIX : `VCP_MIN_UP_PIX;
    assign short_line  = accept && pin_s2.line_end && conv_active
                         && ((line_pix + 16'h0001) < min_pix);

    // Two-flop synchroniser on the pixel pins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= pix_in;
            pin_s2 <= pin_s1;
        end
    end

    // Frame activity and line geometry
    always_ff @(posedge core_clk) begin
        if (port_rst) begin
            frame_busy <= 1'b0;
            line_pix   <= '0;
            line_cnt   <= '0;
            desc_data  <= '0;
        end else if (accept) begin
            frame_busy <= !pin_s2.frame_end;
            line_pix   <= pin_s2.line_end ? '0 : line_pix + 16'h0001;
            if (pin_s2.frame_end) begin
                line_cnt  <= '0;
                desc_data <= {line_cnt + 16'h0001, line_pix + 16'h0001};
            end else if (pin_s2.line_end) begin
                line_cnt <= line_cnt + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage A: colour matrix or chroma upsampling
    always_ff @(posedge core_clk) begin
        if (port_rst || locked) begin
            st_a    <= '0;
            phase_a <= 1'b0;
            cb_hold <= 8'h80;
            cr_hold <= 8'h80;
        end else begin
            st_a           <= pin_s2;
            st_a.valid     <= accept;
            if (accept) begin
                phase_a <= pin_s2.line_end ? 1'b0 : !phase_a;
                case (conv_mode)
                    VCP_CONV_RGB2YUV: st_a.data <= vcp_rgb_to_yuv(pin_s2.data);
                    VCP_CONV_YUV2RGB: begin
                        if (!phase_a) begin
                            cb_hold   <= pin_s2.data[7:0];
                            st_a.data <= {pin_s2.data[15:0], cr_hold};
                        end else begin
                            cr_hold   <= pin_s2.data[7:0];
                            st_a.data <= {pin_s2.data[15:8], cb_hold, pin_s2.data[7:0]};
                        end
                    end
                    default: st_a.data <= pin_s2.data;
                endcase
            end
        end
    end

    // Stage B: chroma downsampling or colour matrix
    always_ff @(posedge core_clk) begin
        if (port_rst || locked) begin
            st_b    <= '0;
            phase_b <= 1'b0;
        end else begin
            st_b <= st_a;
            if (st_a.valid) begin
                phase_b <= st_a.line_end ? 1'b0 : !phase_b;
                case (conv_mode)
                    VCP_CONV_RGB2YUV: st_b.data <= phase_b
                        ? {8'h00, st_a.data[23:16], st_a.data[7:0]}
                        : {8'h00, st_a.data[23:8]};
                    VCP_CONV_YUV2RGB: st_b.data <= vcp_yuv_to_rgb(st_a.data);
                    default:          st_b.data <= st_a.data;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffer writes: data first, descriptor in the next free slot
    assign data_push = st_b.valid;
    assign desc_push = desc_pend && !st_b.valid && fifo_in_ready && !locked;
    // overflow only when the 4K-byte buffer is full
    assign ovf_now   = data_push && !fifo_in_ready;
    // one tiled bit for data and descriptors
    assign wr_word.tiled = tiled_mode;
    assign wr_word.desc  = !data_push;
    // descriptor lands after the frame's last word
    assign wr_word.addr  = frame_addr;
    assign wr_word.data  = data_push ? {8'h00, st_b.data} : desc_data;

    // Frame write address and pending descriptor
    always_ff @(posedge core_clk) begin
        if (port_rst) begin
            frame_addr <= frame_base;
            desc_pend  <= 1'b0;
            data_tiled <= 1'b0;
        end else if (data_push && fifo_in_ready) begin
            frame_addr <= frame_addr + `VCP_ADDR_STEP;
            desc_pend  <= desc_pend || st_b.frame_end;
            data_tiled <= wr_word.tiled;
        end else if (desc_push) begin
            frame_addr <= frame_base;
            desc_pend  <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (port_rst) begin
            overflow_evt <= 1'b0;
        end else begin
            overflow_evt <= ovf_now;
        end
    end

    always_ff @(posedge core_clk) begin
        if (port_rst) begin
            locked <= 1'b0;
        end else if ((ovf_now && conv_active && single_channel) || short_line) begin
            locked <= 1'b1;
        end
    end

    vcp_fifo #(
        .WIDTH ($bits(vcp_wr_t)),
        .DEPTH (`VCP_BUF_WORDS)
    ) u_buf (
        .core_clk  (core_clk),
        .reset     (port_rst),
        .in_valid  (data_push || desc_push),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_word),
        .out_valid (fifo_out_valid),
        .out_ready (dma_ready && !locked),
        .out_data  (fifo_out)
    );

    assign dma_valid = fifo_out_valid && !locked;
    assign dma_wr    = fifo_out;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_port_rst_hold: assert property (@(posedge core_clk) disable iff (reset)
        port_ctrl[`VCP_PORT_RST_BIT] |=> !locked && !st_a.valid && !frame_busy)
        else $error("port reset did not clear the path");
    a_lock_on_ovf: assert property (@(posedge core_clk) disable iff (port_rst)
        ovf_now && conv_active && single_channel |=> locked && overflow_evt)
        else $error("overflow in conversion mode did not lock");
    a_no_lock_other: assert property (@(posedge core_clk) disable iff (port_rst)
        !locked && !short_line && !(ovf_now && conv_active && single_channel) |=> !locked)
        else $error("lockup outside single-channel conversion");
    a_lock_sticky: assert property (@(posedge core_clk) disable iff (reset)
        locked && !port_ctrl[`VCP_PORT_RST_BIT] |=> locked && !dma_valid)
        else $error("locked port released or moved data");
    a_short_line: assert property (@(posedge core_clk) disable iff (port_rst)
        accept && pin_s2.line_end && (conv_mode == VCP_CONV_YUV2RGB)
        && (line_pix < 16'h0003) |=> locked)
        else $error("short upsampled line did not lock");
    a_down_short: assert property (@(posedge core_clk) disable iff (port_rst)
        accept && pin_s2.line_end && (conv_mode == VCP_CONV_RGB2YUV)
        && (line_pix > 16'h0007) |=> !$rose(locked) || $past(ovf_now))
        else $error("nine-pixel line locked the downsampler");
    a_ovf_only_full: assert property (@(posedge core_clk) disable iff (port_rst)
        overflow_evt |-> $past(u_buf.wr_ptr - u_buf.rd_ptr) == 11'(`VCP_BUF_WORDS))
        else $error("overflow without a full buffer");
    a_rgb_path: assert property (@(posedge core_clk) disable iff (port_rst)
        st_a.valid && !locked && (conv_mode == VCP_CONV_RGB2YUV) && $stable(conv_mode)
        |=> st_b.valid && (st_b.data[23:16] == 8'h00))
        else $error("RGB path did not yield 422 words");
    a_addr_step: assert property (@(posedge core_clk) disable iff (port_rst)
        data_push && fifo_in_ready |=> frame_addr == $past(frame_addr) + `VCP_ADDR_STEP)
        else $error("frame address did not advance past data");
    a_desc_tiled: assert property (@(posedge core_clk) disable iff (port_rst)
        desc_push |-> wr_word.desc && (wr_word.tiled == data_tiled))
        else $error("descriptor placement differs from frame data");

endmodule : vcp_capture_port

`default_nettype wire

//--- inc/vcp_defines.svh
/*
 * Constants for the video capture port path: bit positions, limits, sizes.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef VCP_DEFINES_SVH
`define VCP_DEFINES_SVH

`define VCP_PORT_RST_BIT  23
`define VCP_PIX_W         24
`define VCP_ADDR_W        32
`define VCP_DATA_W        32
`define VCP_CNT_W         16
`define VCP_MIN_UP_PIX    16'h0004
`define VCP_MIN_DOWN_PIX  16'h0009
`define VCP_BUF_BYTES     4096
`define VCP_WORD_BYTES    4
`define VCP_BUF_WORDS     (`VCP_BUF_BYTES / `VCP_WORD_BYTES)
`define VCP_ADDR_STEP     32'h0000_0004

`endif

//--- inc/vcp_pkg.sv
/*
 * Types shared by the capture port path, its pixel source and its bench.
 * Assumes vcp_defines.svh is on the include path.
 */
`include "vcp_defines.svh"

package vcp_pkg;

    // Inline colour conversion selection
    typedef enum logic [1:0] {
        VCP_CONV_NONE,
        VCP_CONV_RGB2YUV,
        VCP_CONV_YUV2RGB
    } vcp_conv_t;

    // One pixel with its line and frame markers
    typedef struct packed {
        logic                  valid;
        logic                  line_end;
        logic                  frame_end;
        logic [`VCP_PIX_W-1:0] data;
    } vcp_pix_t;

    // One memory write toward the video DMA
    typedef struct packed {
        logic                   tiled;
        logic                   desc;
        logic [`VCP_ADDR_W-1:0] addr;
        logic [`VCP_DATA_W-1:0] data;
    } vcp_wr_t;

endpackage : vcp_pkg

//--- hw/vcp_fifo.sv
/*
 * Synchronous FIFO in flip-flops, valid/ready on both sides.
 * Assumes DEPTH is a power of two and one clock with synchronous reset.
 */
`timescale 1ns/10ps
`default_nettype none

module vcp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Full when pointers differ only in the wrap bit
    assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign out_valid = (wr_ptr != rd_ptr);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // Storage write
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule : vcp_fifo

`default_nettype wire

//--- dv/vcp_pix_src.sv
/*
 * Pixel source model standing in front of the capture port pins.
 * Assumes one bench process calls its tasks, on core_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module vcp_pix_src (
    input  wire logic             core_clk,
    output var  vcp_pkg::vcp_pix_t pix
);
    import vcp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Pins start idle
    initial begin
        pix = '0;
    end

    // Idle pins keep toggling so stale data never looks settled
    task automatic idle;
        pix.valid = 1'b0;
        pix.line_end = 1'b0;
        pix.frame_end = 1'b0;
        pix.data = ~pix.data;
    endtask : idle

    // line length is the caller's choice
    task automatic send_line(input int n, input bit last, input int gap,
                             input logic [23:0] px, input logic [23:0] st);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            #1;
            pix = '{1'b1, i == n - 1, last && i == n - 1, px + 24'(i) * st};
            repeat (gap) begin
                @(posedge core_clk);
                #1;
                idle();
            end
        end
        @(posedge core_clk);
        #1;
        idle();
    endtask : send_line
endmodule : vcp_pix_src
`default_nettype wire

//--- dv/video_capture_csc_path_tb_top.sv
/*
 * Bench for the capture port path: frame table, lock, recovery, overflow.
 * Assumes vcp_pix_src drives the pins and the bench plays the video DMA.
 */
`timescale 1ns/10ps
`default_nettype none

module video_capture_csc_path_tb_top;
    import vcp_pkg::*;
    typedef struct {
        vcp_conv_t   cm;
        logic        tl;
        int          np;
        int          nl;
        int          gp;
        logic [23:0] px;
        logic [23:0] st;
    } vcp_row_t;
    logic        core_clk;
    logic        reset;
    vcp_pix_t    pix;
    logic [31:0] port_ctrl;
    logic        port_enable;
    vcp_conv_t   conv_mode;
    logic        single_channel;
    logic        tiled_mode;
    logic [31:0] frame_base;
    vcp_wr_t     dma_wr;
    logic        dma_valid;
    logic        dma_ready;
    logic        overflow_evt;
    logic        locked;
    logic        frame_busy;
    int          miscompares;
    int          n_compared;
    int          n_ovf;
    int          ovf0;
    int          rmode;
    int          n;
    logic        ok;
    logic [31:0] fb;
    vcp_wr_t     w;
    vcp_row_t    vr;
    vcp_wr_t     got[$];
    vcp_row_t    rows[4];

    vcp_pix_src vcp_pix_src_i (.core_clk(core_clk), .pix(pix));
    vcp_capture_port vcp_capture_port_i (
        .core_clk(core_clk), .reset(reset), .pix_in(pix), .port_ctrl(port_ctrl),
        .port_enable(port_enable), .conv_mode(conv_mode),
        .single_channel(single_channel), .tiled_mode(tiled_mode),
        .frame_base(frame_base), .dma_wr(dma_wr), .dma_valid(dma_valid),
        .dma_ready(dma_ready), .overflow_evt(overflow_evt), .locked(locked),
        .frame_busy(frame_busy));

    ////////////////////////////////////////////////////////////////////
    // Clock, DMA side acceptance, word and overflow capture
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (dma_valid === 1'b1 && dma_ready === 1'b1) got.push_back(dma_wr);
        if (overflow_evt === 1'b1) n_ovf++;
        #1;
        dma_ready = (rmode == 2) ? ~dma_ready : (rmode == 1);
    end

    ////////////////////////////////////////////////////////////////////
    // Compare, report and wait helpers
    task automatic chk(input logic [65:0] g, input logic [65:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic close_out;
        $display("compared=%0d mismatches=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task automatic wait_words(input int k);
        int t;
        t = 0;
        while (got.size() < k && t < 4000) begin
            @(posedge core_clk);
            #1;
            t++;
        end
        if (got.size() < k) begin
            miscompares++;
            $display("[FAIL] t=%0t words=%h exp=%h", $time, got.size(), k);
            close_out();
        end
    endtask : wait_words
    task automatic settle(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic frame(input int np, input int nl, input int gp,
                         input logic [23:0] px, input logic [23:0] st);
        for (int l = 0; l < nl; l++) begin
            vcp_pix_src_i.send_line(np, l == nl - 1, gp, px + 24'(l * np) * st, st);
        end
    endtask : frame
    task automatic port_rst(input logic [31:0] b, input bit strict);
        int t;
        t = 0;
        port_enable = 1'b0;
        while (frame_busy !== 1'b0 && t < 100) begin
            settle(1);
            t++;
        end
        if (strict && frame_busy !== 1'b0) begin
            miscompares++;
            $display("[FAIL] t=%0t busy=%h exp=%h", $time, frame_busy, 1'b0);
            close_out();
        end
        frame_base = b;
        port_ctrl[23] = 1'b1;
        settle(2);
        chk({dma_valid, locked, overflow_evt, frame_busy}, 0);
        port_ctrl[23] = 1'b0;
        got.delete();
        port_enable = 1'b1;
    endtask : port_rst

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset = 1'b1;
        port_ctrl = '0;
        port_enable = 1'b0;
        conv_mode = VCP_CONV_NONE;
        single_channel = 1'b1;
        tiled_mode = 1'b0;
        frame_base = '0;
        rmode = 1;
        miscompares = 0;
        n_compared = 0;
        rows = '{'{VCP_CONV_NONE, 1'b0, 5, 2, 0, 24'h123456, 24'h010203},
                 '{VCP_CONV_RGB2YUV, 1'b1, 9, 2, 0, 24'h808080, 24'h000000},
                 '{VCP_CONV_YUV2RGB, 1'b0, 4, 3, 1, 24'h008080, 24'h000000},
                 '{VCP_CONV_NONE, 1'b1, 3, 1, 0, 24'hFFFFF0, 24'h000001}};
        settle(8);
        chk({dma_valid, locked, overflow_evt, frame_busy}, 0);
        reset = 1'b0;
        $display("test reset done");
        // Frame table with a stalling DMA side
        for (int r = 0; r < 4; r++) begin
            vr = rows[r];
            fb = 32'h1000_0000 + 32'(r) * 32'h0000_1000;
            conv_mode = vr.cm;
            tiled_mode = vr.tl;
            rmode = 2;
            port_rst(fb, 1);
            frame(vr.np, vr.nl, vr.gp, vr.px, vr.st);
            n = vr.np * vr.nl;
            wait_words(n + 1);
            settle(20);
            chk(66'(got.size()), 66'(n + 1));
            for (int i = 0; i < n; i++) begin
                w = got[i];
                chk({w.tiled, w.desc, w.addr}, {vr.tl, 1'b0, fb + 32'(4 * i)});
                case (vr.cm)
                    VCP_CONV_NONE: ok = w.data === {8'h00, vr.px + 24'(i) * vr.st};
                    VCP_CONV_RGB2YUV: ok = w.data[31:24] === 8'h00
                        && w.data[7:0] inside {[8'h7E:8'h82]};
                    default: ok = 8'(w.data[23:16] - w.data[15:8] + 8'h02) <= 8'h04
                        && 8'(w.data[15:8] - w.data[7:0] + 8'h02) <= 8'h04;
                endcase
                chk(66'(ok), 66'(1));
            end
            chk(got[n], {vr.tl, 1'b1, fb + 32'(4 * n), 16'(vr.nl), 16'(vr.np)});
            chk({locked, frame_busy}, 0);
            $display("test row %0d done", r);
        end
        for (int c = 0; c < 2; c++) begin
            conv_mode = c ? VCP_CONV_RGB2YUV : VCP_CONV_YUV2RGB;
            rmode = 1;
            port_rst(32'h2000_0000, 1);
            vcp_pix_src_i.send_line(c ? 8 : 3, 1, 0, 24'h008080, 24'h0);
            settle(12);
            chk(locked, 1);
            frame(16, 1, 0, 24'h008080, 24'h0);
            settle(12);
            chk({locked, dma_valid}, 2'b10);
            port_rst(32'h2000_0000, 1);
            frame(16, 1, 0, 24'h008080, 24'h0);
            wait_words(17);
            chk(got[16].desc, 1);
            $display("test lock %0d done", c);
        end
        for (int c = 0; c < 3; c++) begin
            conv_mode = c ? VCP_CONV_RGB2YUV : VCP_CONV_NONE;
            single_channel = c == 2;
            rmode = 0;
            port_rst(32'h3000_0000, 0);
            ovf0 = n_ovf;
            frame(16, 64, 0, 24'h808080, 24'h0);
            settle(10);
            chk(66'(n_ovf - ovf0), 0);
            frame(16, 1, 0, 24'h808080, 24'h0);
            settle(10);
            chk(66'(n_ovf != ovf0), 1);
            chk(locked, 66'(c == 2));
            if (c < 2) begin
                chk(66'(n_ovf - ovf0), 16);
                rmode = 1;
                wait_words(1024);
                chk(got[1023].addr, 32'h3000_0FFC);
            end
            $display("test overflow %0d done", c);
        end
        close_out();
    end
endmodule : video_capture_csc_path_tb_top
`default_nettype wire
